// ===== core/cpu_register_file.sv
// Purpose: General purpose and system registers, PC and PC/PROGRAM_STATUS save
// Assumes: Pipeline supplies one-cycle retire strobes on ref_clk_in
// Notes:   Reserved system numbers read zero and ignore writes
`timescale 1ns/10ps
`default_nettype none

module cpu_register_file (
  input  wire logic                             ref_clk_in,
  input  wire logic                             reset_in,
  input  wire logic [cpu_regs_pkg::GPR_SEL_W-1:0] rd_sel_a_in,
  input  wire logic [cpu_regs_pkg::GPR_SEL_W-1:0] rd_sel_b_in,
  input  wire logic                             gpr_wr_in,
  input  wire logic [cpu_regs_pkg::GPR_SEL_W-1:0] gpr_wr_sel_in,
  input  wire logic [cpu_regs_pkg::DATA_W-1:0]    gpr_wr_data_in,
  input  wire logic                             load_sysreg_instr_in,
  input  wire logic                             store_sysreg_instr_in,
  input  wire logic [cpu_regs_pkg::SYS_SEL_W-1:0] sysreg_number_in,
  input  wire logic [cpu_regs_pkg::DATA_W-1:0]    sysreg_wr_data_in,
  input  wire logic                             retire_in,
  input  wire logic                             branch_in,
  input  wire logic [cpu_regs_pkg::DATA_W-1:0]    branch_target_in,
  input  wire logic [cpu_regs_pkg::DATA_W-1:0]    next_pc_in,
  input  wire logic                             sw_exception_in,
  input  wire logic                             maskable_int_in,
  input  wire logic                             nmi_in,
  input  wire logic                             exception_trap_in,
  input  wire logic                             debug_break_in,
  input  wire logic                             single_step_in,
  input  wire logic                             illegal_opcode_detect_in,
  input  wire logic                             table_call_instr_in,
  input  wire logic                             debug_return_instr_in,
  input  wire logic                             interrupt_source_wr_in,
  input  wire logic [cpu_regs_pkg::DATA_W-1:0]    interrupt_source_in,
  input  wire logic                             psw_update_in,
  input  wire logic [cpu_regs_pkg::DATA_W-1:0]    psw_update_data_in,
  output logic [cpu_regs_pkg::DATA_W-1:0]         rd_data_a_out,
  output logic [cpu_regs_pkg::DATA_W-1:0]         rd_data_b_out,
  output logic [cpu_regs_pkg::DATA_W-1:0]         element_base_out,
  output logic [cpu_regs_pkg::DATA_W-1:0]         sysreg_rd_data_out,
  output logic                                  sysreg_rd_valid_out,
  output logic [cpu_regs_pkg::DATA_W-1:0]         pc_out,
  output logic [cpu_regs_pkg::DATA_W-1:0]         program_status_out,
  output logic [cpu_regs_pkg::DATA_W-1:0]         table_call_instr_base_pointer_out,
  output logic                                  debug_trap_exception_out,
  output logic                                  debug_mode_out
);
  import cpu_regs_pkg::*;

  logic [DATA_W-1:0] gpr_mem [GPR_COUNT];
  logic [PC_W-1:1]   pc_reg;
  logic [PC_W-1:1]   int_pc_save_reg;
  logic [PC_W-1:1]   nmi_pc_save_reg;
  logic [PC_W-1:1]   table_call_instr_pc_save_reg;
  logic [PC_W-1:1]   debug_pc_save_reg;
  logic [DATA_W-1:0] int_psw_save_reg;
  logic [DATA_W-1:0] nmi_psw_save_reg;
  logic [DATA_W-1:0] table_call_instr_psw_save_reg;
  logic [DATA_W-1:0] debug_psw_save_reg;
  logic [DATA_W-1:0] interrupt_source_reg;
  logic [DATA_W-1:0] program_status_reg;
  logic [DATA_W-1:0] table_call_instr_base_pointer_reg;
  logic              debug_mode_reg;
  logic              debug_mode_next;
  logic [PC_W-1:1]   next_pc_field;
  logic [PC_W-1:1]   pc_next;
  logic              sys_wr;
  logic              debug_entry;
  logic [DATA_W-1:0] sys_rd_next;
  logic              wr_int_pc_save;
  logic              wr_int_psw_save;
  logic              wr_nmi_pc_save;
  logic              wr_nmi_psw_save;
  logic              wr_table_call_instr_pc_save;
  logic              wr_table_call_instr_psw_save;
  logic              wr_debug_pc_save;
  logic              wr_debug_psw_save;
  logic              int_save_event;
  logic              nmi_save_event;
  logic              table_call_instr_save_event;

  function automatic logic [DATA_W-1:0] pc_word(input logic [PC_W-1:1] f);
    pc_word = {6'h00, f, 1'b0};
  endfunction

  // Next address field; upper bits and bit 0 fall away
  assign next_pc_field = next_pc_in[PC_W-1:1];
  assign sys_wr        = load_sysreg_instr_in && retire_in;
  assign debug_entry   = exception_trap_in || debug_break_in ||
                         single_step_in || illegal_opcode_detect_in;

  // One write strobe per save register, all gated by retirement
  assign wr_int_pc_save    = sys_wr && sysreg_number_in == SR_INT_PC_SAVE;
  assign wr_int_psw_save   = sys_wr && sysreg_number_in == SR_INT_PSW_SAVE;
  assign wr_nmi_pc_save    = sys_wr && sysreg_number_in == SR_NMI_PC_SAVE;
  assign wr_nmi_psw_save   = sys_wr && sysreg_number_in == SR_NMI_PSW_SAVE;
  assign wr_table_call_instr_pc_save  = sys_wr && sysreg_number_in == SR_TABLE_CALL_INSTR_PC_SAVE;
  assign wr_table_call_instr_psw_save = sys_wr && sysreg_number_in == SR_TABLE_CALL_INSTR_PSW_SAVE;
  assign wr_debug_pc_save  = sys_wr && sysreg_number_in == SR_DEBUG_PC_SAVE;
  assign wr_debug_psw_save = sys_wr && sysreg_number_in == SR_DEBUG_PSW_SAVE;

  // Save events; table call saves only when it really completes
  assign int_save_event    = sw_exception_in || maskable_int_in;
  assign nmi_save_event    = nmi_in;
  assign table_call_instr_save_event  = table_call_instr_in && retire_in;

  // General registers, zero entry never written
  always_ff @(posedge ref_clk_in) begin
    if (gpr_wr_in && retire_in && gpr_wr_sel_in != GPR_ZERO) begin
      gpr_mem[gpr_wr_sel_in] <= gpr_wr_data_in;
    end
  end

  // Register outputs; zero register forced on read
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rd_data_a_out    <= ZERO_WORD;
      rd_data_b_out    <= ZERO_WORD;
    end else begin
      rd_data_a_out    <= (rd_sel_a_in == GPR_ZERO) ? ZERO_WORD
                          : gpr_mem[rd_sel_a_in];
      rd_data_b_out    <= (rd_sel_b_in == GPR_ZERO) ? ZERO_WORD
                          : gpr_mem[rd_sel_b_in];
    end
  end

  // Dedicated port so short accesses need no read port of their own
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      element_base_out <= ZERO_WORD;
    end else begin
      element_base_out <= gpr_mem[GPR_ELEMENT];
    end
  end

  // PC steps by one halfword unit; wrap is the field width itself
  always_comb begin
    pc_next = pc_reg;
    if (retire_in) begin
      if (branch_in) begin
        pc_next = branch_target_in[PC_W-1:1];
      end else begin
        pc_next = pc_reg + PC_INC[PC_W-1:1];
      end
    end
    if (debug_entry) begin
      pc_next = DEBUG_VECTOR[PC_W-1:1];
    end
  end

  // Not reachable from any system register number
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pc_reg <= PC_RESET[PC_W-1:1];
    end else begin
      pc_reg <= pc_next;
    end
  end

  // Save registers carry no reset, matching undefined contents
  // Capture outranks a same-cycle write to the same register
  always_ff @(posedge ref_clk_in) begin
    if (int_save_event) begin
      int_pc_save_reg <= next_pc_field;
    end else if (wr_int_pc_save) begin
      int_pc_save_reg <= sysreg_wr_data_in[PC_W-1:1];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (int_save_event) begin
      int_psw_save_reg <= program_status_reg;
    end else if (wr_int_psw_save) begin
      int_psw_save_reg <= sysreg_wr_data_in;
    end
  end

  // Single register per class; nesting software must copy it first
  always_ff @(posedge ref_clk_in) begin
    if (nmi_save_event) begin
      nmi_pc_save_reg <= next_pc_field;
    end else if (wr_nmi_pc_save) begin
      nmi_pc_save_reg <= sysreg_wr_data_in[PC_W-1:1];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (nmi_save_event) begin
      nmi_psw_save_reg <= program_status_reg;
    end else if (wr_nmi_psw_save) begin
      nmi_psw_save_reg <= sysreg_wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (table_call_instr_save_event) begin
      table_call_instr_pc_save_reg <= next_pc_field;
    end else if (wr_table_call_instr_pc_save) begin
      table_call_instr_pc_save_reg <= sysreg_wr_data_in[PC_W-1:1];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (table_call_instr_save_event) begin
      table_call_instr_psw_save_reg <= program_status_reg;
    end else if (wr_table_call_instr_psw_save) begin
      table_call_instr_psw_save_reg <= sysreg_wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (debug_entry) begin
      debug_pc_save_reg <= next_pc_field;
    end else if (wr_debug_pc_save) begin
      debug_pc_save_reg <= sysreg_wr_data_in[PC_W-1:1];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (debug_entry) begin
      debug_psw_save_reg <= program_status_reg;
    end else if (wr_debug_psw_save) begin
      debug_psw_save_reg <= sysreg_wr_data_in;
    end
  end

  // Interrupt source is set by the controller only
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      interrupt_source_reg <= ZERO_WORD;
    end else if (interrupt_source_wr_in) begin
      interrupt_source_reg <= interrupt_source_in;
    end
  end

  // Instruction write outranks a flag update in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      program_status_reg <= PSW_RESET;
    end else if (sys_wr && sysreg_number_in == SR_PROGRAM_STATUS) begin
      program_status_reg <= sysreg_wr_data_in;
    end else if (psw_update_in) begin
      program_status_reg <= psw_update_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      table_call_instr_base_pointer_reg <= ZERO_WORD;
    end else if (sys_wr && sysreg_number_in == SR_TABLE_CALL_INSTR_BASE) begin
      table_call_instr_base_pointer_reg <= sysreg_wr_data_in;
    end
  end

  // Entry wins over a return in the same cycle
  always_comb begin
    debug_mode_next = debug_mode_reg;
    if (debug_return_instr_in && retire_in) begin
      debug_mode_next = 1'b0;
    end
    if (debug_entry) begin
      debug_mode_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      debug_mode_reg <= 1'b0;
    end else begin
      debug_mode_reg <= debug_mode_next;
    end
  end

  // Reserved numbers read zero; that is a choice, not a promise
  always_comb begin
    case (sysreg_number_in)
      SR_INT_PC_SAVE:    sys_rd_next = pc_word(int_pc_save_reg);
      SR_INT_PSW_SAVE:   sys_rd_next = int_psw_save_reg;
      SR_NMI_PC_SAVE:    sys_rd_next = pc_word(nmi_pc_save_reg);
      SR_NMI_PSW_SAVE:   sys_rd_next = nmi_psw_save_reg;
      SR_INT_SOURCE:     sys_rd_next = interrupt_source_reg;
      SR_PROGRAM_STATUS: sys_rd_next = program_status_reg;
      SR_TABLE_CALL_INSTR_PC_SAVE:  sys_rd_next = pc_word(table_call_instr_pc_save_reg);
      SR_TABLE_CALL_INSTR_PSW_SAVE: sys_rd_next = table_call_instr_psw_save_reg;
      SR_DEBUG_PC_SAVE:  sys_rd_next = debug_mode_reg
                         ? pc_word(debug_pc_save_reg) : ZERO_WORD;
      SR_DEBUG_PSW_SAVE: sys_rd_next = debug_mode_reg
                         ? debug_psw_save_reg : ZERO_WORD;
      SR_TABLE_CALL_INSTR_BASE:     sys_rd_next = table_call_instr_base_pointer_reg;
      default:           sys_rd_next = ZERO_WORD;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sysreg_rd_data_out  <= ZERO_WORD;
      sysreg_rd_valid_out <= 1'b0;
    end else begin
      sysreg_rd_valid_out <= store_sysreg_instr_in;
      sysreg_rd_data_out  <= store_sysreg_instr_in ? sys_rd_next
                             : ZERO_WORD;
    end
  end

  // Copy of the PC taken from its next value, so no extra cycle lag
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pc_out <= PC_RESET;
    end else begin
      pc_out <= pc_word(pc_next);
    end
  end

  // Status views lag the internal registers by one cycle
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      program_status_out     <= PSW_RESET;
      table_call_instr_base_pointer_out <= ZERO_WORD;
    end else begin
      program_status_out     <= program_status_reg;
      table_call_instr_base_pointer_out <= table_call_instr_base_pointer_reg;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      debug_trap_exception_out <= 1'b0;
      debug_mode_out           <= 1'b0;
    end else begin
      debug_trap_exception_out <= illegal_opcode_detect_in;
      debug_mode_out           <= debug_mode_next;
    end
  end

endmodule // cpu_register_file

`default_nettype wire

// ===== core/cpu_regs_pkg.sv
// Purpose: Constants for the CPU register file and PC save logic
// Assumes: Single 125 MHz clock, synchronous active-high reset
// Notes:   System register numbers are the documented identifiers
package cpu_regs_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned GPR_COUNT  = 32;
  localparam int unsigned GPR_SEL_W  = 5;
  localparam int unsigned SYS_SEL_W  = 5;
  localparam int unsigned PC_W       = 26;

  localparam logic [4:0] GPR_ZERO    = 5'h00;
  localparam logic [4:0] GPR_ELEMENT = 5'h1e;

  localparam logic [4:0] SR_INT_PC_SAVE    = 5'h00;
  localparam logic [4:0] SR_INT_PSW_SAVE   = 5'h01;
  localparam logic [4:0] SR_NMI_PC_SAVE    = 5'h02;
  localparam logic [4:0] SR_NMI_PSW_SAVE   = 5'h03;
  localparam logic [4:0] SR_INT_SOURCE     = 5'h04;
  localparam logic [4:0] SR_PROGRAM_STATUS = 5'h05;
  localparam logic [4:0] SR_TABLE_CALL_INSTR_PC_SAVE  = 5'h10;
  localparam logic [4:0] SR_TABLE_CALL_INSTR_PSW_SAVE = 5'h11;
  localparam logic [4:0] SR_DEBUG_PC_SAVE  = 5'h12;
  localparam logic [4:0] SR_DEBUG_PSW_SAVE = 5'h13;
  localparam logic [4:0] SR_TABLE_CALL_INSTR_BASE     = 5'h14;

  localparam logic [31:0] PC_RESET      = 32'h0000_0000;
  localparam logic [31:0] PSW_RESET     = 32'h0000_0020;
  localparam logic [31:0] DEBUG_VECTOR  = 32'h0000_0060;
  localparam logic [25:0] PC_INC        = 26'h000_0002;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
endpackage : cpu_regs_pkg

// ===== sim/cpu_register_file_and_pc_save_bench.sv
// Purpose: Self-checking bench for the CPU register file
// Assumes: Inputs change on the falling edge of ref_clk_in
// Notes:   Reserved system numbers are never touched
`timescale 1ns/10ps
`default_nettype none
module cpu_register_file_and_pc_save_bench;
  import cpu_regs_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [4:0]  rd_sel_a_in = 5'h00, rd_sel_b_in = 5'h00;
  logic [4:0]  gpr_wr_sel_in = 5'h00, sysreg_number_in = 5'h00;
  logic        gpr_wr_in, load_sysreg_instr_in, store_sysreg_instr_in;
  logic        retire_in, branch_in, debug_return_instr_in;
  logic        interrupt_source_wr_in, psw_update_in;
  logic [31:0] gpr_wr_data_in = 32'h0, sysreg_wr_data_in = 32'h0;
  logic [31:0] branch_target_in = 32'h0, interrupt_source_in = 32'h0;
  logic [31:0] psw_update_data_in = 32'h0, exp_pc = 32'h0, e;
  logic [7:0]  ev;
  wire  logic  sw_exception_in = ev[0], maskable_int_in = ev[1];
  wire  logic  nmi_in = ev[2], exception_trap_in = ev[3];
  wire  logic  debug_break_in = ev[4], single_step_in = ev[5];
  wire  logic  illegal_opcode_detect_in = ev[6];
  wire  logic  table_call_instr_in = ev[7];
  wire  logic [31:0] next_pc_in;
  logic [31:0] rd_data_a_out, rd_data_b_out, element_base_out, pc_out;
  logic [31:0] sysreg_rd_data_out, program_status_out;
  logic [31:0] table_call_instr_base_pointer_out;
  logic        sysreg_rd_valid_out, debug_trap_exception_out, debug_mode_out;
  logic [4:0]  sr [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h05,
                          5'h14};
  logic [4:0]  evn [8] = '{5'h00, 5'h00, 5'h02, 5'h12, 5'h12, 5'h12,
                           5'h12, 5'h10};
  int          bad_count = 0, n_checks = 0, cycles = 0;

  cpu_register_file dut (.*);
  pipeline_model partner (.ref_clk_in, .pc_in(pc_out),
                          .next_pc_out(next_pc_in));

  initial forever #4 ref_clk_in = ~ref_clk_in;

  function automatic logic [31:0] gw(int i);
    return {4{i[7:0]}} ^ 32'ha5a5_a5a5;
  endfunction
  task automatic idle();
    {gpr_wr_in, load_sysreg_instr_in, store_sysreg_instr_in} = 3'h0;
    {retire_in, branch_in, debug_return_instr_in} = 3'h0;
    {interrupt_source_wr_in, psw_update_in} = 2'h0;
    ev = 8'h00;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bench keeps its own pc so every cycle checks the design's
  task automatic cyc();
    if (|ev[6:3]) exp_pc = DEBUG_VECTOR;
    else if (retire_in && branch_in) exp_pc = branch_target_in & 32'h03ff_fffe;
    else if (retire_in) exp_pc = {6'h00, exp_pc[25:0] + PC_INC};
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    idle();
    chk(pc_out, exp_pc);
  endtask
  task automatic rd_sys(input logic [4:0] n, input logic [31:0] exp);
    store_sysreg_instr_in = 1'b1;
    sysreg_number_in = n;
    cyc();
    chk({31'h0, sysreg_rd_valid_out}, 32'h1);
    chk(sysreg_rd_data_out, exp);
  endtask
  task automatic wr_sys(input logic [4:0] n, input logic [31:0] d);
    {load_sysreg_instr_in, retire_in} = 2'h3;
    sysreg_number_in = n;
    sysreg_wr_data_in = d;
    cyc();
  endtask
  task automatic test_done();
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    idle();
    repeat (4) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    reset_in = 1'b0;
    chk(pc_out, PC_RESET);
    chk(program_status_out, PSW_RESET);
    for (int i = 0; i < 32; i++) begin
      {gpr_wr_in, retire_in} = 2'h3;
      gpr_wr_sel_in = i[4:0];
      gpr_wr_data_in = gw(i);
      cyc();
    end
    for (int i = 0; i < 32; i++) begin
      rd_sel_a_in = i[4:0];
      rd_sel_b_in = 5'h1f - i[4:0];
      cyc();
      chk(rd_data_a_out, (i == 0) ? 32'h0 : gw(i));
      chk(rd_data_b_out, (i == 31) ? 32'h0 : gw(31 - i));
    end
    chk(element_base_out, gw(30));
    // Odd, wide value into pc saves; only bits 25:1 may stick
    foreach (sr[i]) begin
      e = (sr[i] inside {5'h00, 5'h02, 5'h10}) ? 32'hfc00_1235 : 32'h40 | i;
      wr_sys(sr[i], e);
      rd_sys(sr[i], (e[31]) ? 32'h0000_1234 : e);
    end
    chk(program_status_out, 32'h46);
    chk(table_call_instr_base_pointer_out, 32'h47);
    {interrupt_source_wr_in, interrupt_source_in} = {1'b1, 32'h0000_0050};
    cyc();
    wr_sys(SR_INT_SOURCE, 32'h0000_0777);
    rd_sys(SR_INT_SOURCE, 32'h0000_0050);
    {psw_update_in, psw_update_data_in} = {1'b1, 32'h0000_0007};
    cyc();
    rd_sys(SR_PROGRAM_STATUS, 32'h0000_0007);
    rd_sys(SR_DEBUG_PC_SAVE, 32'h0);
    // Each save is read back before the next event may overwrite it
    for (int k = 0; k < 8; k++) begin
      e = {6'h00, exp_pc[25:0] + PC_INC};
      ev = 8'h01 << k;
      retire_in = (k == 7);
      cyc();
      if (k == 6) chk({31'h0, debug_trap_exception_out}, 32'h1);
      rd_sys(evn[k], e);
      rd_sys(evn[k] + 5'h01, 32'h0000_0007);
      if (k inside {[3:6]}) begin
        {retire_in, debug_return_instr_in} = 2'h3;
        cyc();
        rd_sys(SR_DEBUG_PC_SAVE, 32'h0);
      end
    end
    {retire_in, branch_in, branch_target_in} = {2'h3, 32'hffff_ffff};
    cyc();
    retire_in = 1'b1;
    cyc();
    reset_in = 1'b1;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    reset_in = 1'b0;
    chk(pc_out, PC_RESET);
    chk(program_status_out, PSW_RESET);
    test_done();
  end
endmodule // cpu_register_file_and_pc_save_bench
`default_nettype wire

// ===== sim/cpu_regs_properties.sv
// Purpose: Port-level checks for the CPU register file
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module cpu_regs_properties
  import cpu_regs_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        reset_in,
  input wire logic [4:0]  rd_sel_a_in,
  input wire logic        retire_in,
  input wire logic        branch_in,
  input wire logic        store_sysreg_instr_in,
  input wire logic [4:0]  sysreg_number_in,
  input wire logic        exception_trap_in,
  input wire logic        debug_break_in,
  input wire logic        single_step_in,
  input wire logic        illegal_opcode_detect_in,
  input wire logic [31:0] rd_data_a_out,
  input wire logic [31:0] sysreg_rd_data_out,
  input wire logic        sysreg_rd_valid_out,
  input wire logic [31:0] pc_out,
  input wire logic [31:0] program_status_out,
  input wire logic        debug_trap_exception_out,
  input wire logic        debug_mode_out
);
  logic dbg_ev;
  assign dbg_ev = exception_trap_in | debug_break_in | single_step_in
                | illegal_opcode_detect_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  reset_values_a: assert property (
    $fell(reset_in) |-> pc_out == PC_RESET
      && program_status_out == PSW_RESET) else $error("bad reset values");
  zero_reg_a: assert property (
    rd_sel_a_in == GPR_ZERO |=> rd_data_a_out == ZERO_WORD)
    else $error("register zero not zero");
  pc_layout_a: assert property (
    pc_out[31:26] == 6'h00 && !pc_out[0]) else $error("bad pc layout");
  pc_advance_a: assert property (
    retire_in && !branch_in && !dbg_ev
      |=> pc_out[25:0] == $past(pc_out[25:0]) + PC_INC)
    else $error("pc did not advance by two");
  debug_entry_a: assert property (
    dbg_ev |=> pc_out == DEBUG_VECTOR && debug_mode_out)
    else $error("debug entry missed");
  trap_pulse_a: assert property (
    illegal_opcode_detect_in |=> debug_trap_exception_out)
    else $error("no trap on illegal opcode");
  read_answer_a: assert property (
    store_sysreg_instr_in |=> sysreg_rd_valid_out)
    else $error("store read not answered");
  read_alone_a: assert property (
    sysreg_rd_valid_out |-> $past(store_sysreg_instr_in))
    else $error("read answer without request");
  debug_gate_a: assert property (
    store_sysreg_instr_in && sysreg_number_in[4:1] == 4'h9
      && !debug_mode_out && !dbg_ev |=> sysreg_rd_data_out == ZERO_WORD)
    else $error("debug save readable outside window");
endmodule // cpu_regs_properties
bind cpu_register_file cpu_regs_properties props (.*);
`default_nettype wire

// ===== sim/pipeline_model.sv
// Purpose: Pipeline stand-in supplying the next instruction address
// Assumes: Instructions two bytes apart, addresses wrap at 26 bits
// Notes:   Updates on the falling edge, clear of the sampling edge
`timescale 1ns/10ps
`default_nettype none
module pipeline_model (
  input  wire logic        ref_clk_in,
  input  wire logic [31:0] pc_in,
  output logic      [31:0] next_pc_out
);
  import cpu_regs_pkg::*;
  initial next_pc_out = 32'h0000_0002;
  always @(negedge ref_clk_in) begin
    next_pc_out <= {6'h00, pc_in[25:0] + PC_INC};
  end
endmodule // pipeline_model
`default_nettype wire
